// ### hw/sbcwd_watchdog.sv
`timescale 1ns/1ns
// Watchdog supervisor with its register file.
module sbcwd_watchdog import sbcwd_pkg::*; #(
	parameter int unsigned TICK_CYC = TICK_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire sbcwd_reg_req_t reg_req_i,
	input wire sbcwd_chip_mode_t chip_mode_i,
	input wire logic rxd_low_i,
	input wire logic wake_up_captured_i,
	input wire logic wake_clear_i,
	input wire logic failure_clear_i,
	input wire logic serial_failure_enable_i,
	input wire logic off_exit_i,
	input wire logic overtemp_exit_i,
	input wire logic undervoltage_i,
	input wire logic reset_pin_low_i,
	output logic [7:0] reg_rdata_o,
	output logic sys_reset_req_o,
	output logic serial_failure_event_o,
	output logic supervisor_failure_event_o,
	output logic wake_signal_low_o,
	output logic [1:0] supervisor_state_o,
	output logic forced_normal_enable_o,
	output logic software_dev_enable_o,
	output logic [1:0] startup_undervoltage_level_o,
	output logic [6:0] undervoltage_percent_o
);

	////////////////////////////////////////////////////////////////////////////
	// State.
	logic [2:0] supervisor_mode_select;
	logic [3:0] supervisor_period_select;
	logic forced_normal_enable;
	logic software_dev_enable;
	logic [1:0] startup_undervoltage_level;
	logic normal_entry_pending;
	logic [4:0] reset_origin;
	logic failure_pending;
	logic wake_low;
	logic [12:0] count;
	sbcwd_wd_state_t wd_state;
	sbcwd_wd_state_t next_wd_state;

	logic tick;
	logic wr_mode_ok;
	logic wr_period_ok;
	logic [12:0] wr_period_ms;
	logic [12:0] period_ms;
	logic [2:0] wr_mode;
	logic [3:0] wr_period;
	logic wr_ctrl;
	logic wr_boot;
	logic code_ok;
	logic changed;
	logic illegal;
	logic accept;
	logic bad_code;
	logic wake_restart;
	logic running;
	logic overflow;
	logic early;
	logic fail_reset;
	logic restart;
	logic [12:0] count_inc;
	logic [12:0] half_ms;
	logic eff_rxd_low;

	////////////////////////////////////////////////////////////////////////////
	// Timebase and code decoders.
	sbcwd_tick_gen #(
		.CYCLES(TICK_CYC)
	) u_tick (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.tick_o(tick)
	);

	// Checks the incoming write.
	sbcwd_code_check u_wr_check (
		.mode_code_i(wr_mode),
		.period_code_i(wr_period),
		.mode_ok_o(wr_mode_ok),
		.period_ok_o(wr_period_ok),
		.period_ms_o(wr_period_ms)
	);

	// Decodes the stored period for the running timer.
	sbcwd_code_check u_cur_check (
		.mode_code_i(supervisor_mode_select),
		.period_code_i(supervisor_period_select),
		.mode_ok_o(),
		.period_ok_o(),
		.period_ms_o(period_ms)
	);

	////////////////////////////////////////////////////////////////////////////
	// Write classification.
	assign wr_mode = reg_req_i.wdata[MODE_LSB +: 3];
	assign wr_period = reg_req_i.wdata[PERIOD_LSB +: 4];
	assign wr_ctrl = reg_req_i.wr && (reg_req_i.addr == ADDR_WATCHDOG_CONTROL);
	assign wr_boot = reg_req_i.wr && (reg_req_i.addr == ADDR_BOOT_CONFIGURATION);
	assign code_ok = wr_mode_ok && wr_period_ok;
	assign changed = (wr_mode != supervisor_mode_select) || (wr_period != supervisor_period_select);
	// Reconfiguration in Normal is refused, relying on software to change it in Standby.
	assign illegal = wr_ctrl && code_ok && changed && (chip_mode_i == CHIP_NORMAL);
	assign accept = wr_ctrl && code_ok && !illegal;
	assign bad_code = wr_ctrl && !code_ok;

	////////////////////////////////////////////////////////////////////////////
	// Effective watchdog operation from mode field, chip mode and boot bits.
	assign eff_rxd_low = rxd_low_i || wake_low;
	always_comb begin
		next_wd_state = WD_OFF;
		if (!forced_normal_enable && (chip_mode_i != CHIP_FORCED_NORMAL)) begin
			case (chip_mode_i)
				CHIP_NORMAL: begin
					if (supervisor_mode_select == MODE_WINDOW) begin
						next_wd_state = WD_WINDOW;
					end else if (supervisor_mode_select == MODE_TIMEOUT) begin
						next_wd_state = WD_TIMEOUT;
					end else if (!software_dev_enable) begin
						next_wd_state = WD_TIMEOUT;
					end
				end
				CHIP_STANDBY: begin
					// Window waits for Normal; Timeout here doubles as cyclic wake-up.
					if (supervisor_mode_select != MODE_AUTONOMOUS) begin
						next_wd_state = WD_TIMEOUT;
					end else if (!software_dev_enable && eff_rxd_low) begin
						next_wd_state = WD_TIMEOUT;
					end
				end
				CHIP_SLEEP: begin
					if (supervisor_mode_select != MODE_AUTONOMOUS) begin
						next_wd_state = WD_TIMEOUT;
					end
				end
				default: next_wd_state = WD_OFF;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Timer events.
	assign running = (wd_state != WD_OFF);
	assign count_inc = 13'(count + 13'h0001);
	assign half_ms = period_ms >> 1;
	assign overflow = running && tick && (count_inc >= period_ms);
	assign early = accept && (wd_state == WD_WINDOW) && (count < half_ms);
	assign fail_reset = overflow && ((wd_state == WD_WINDOW) || failure_pending);
	assign wake_restart = wake_up_captured_i && (chip_mode_i == CHIP_STANDBY) &&
		(supervisor_mode_select == MODE_AUTONOMOUS);
	assign restart = accept || wake_restart || (wd_state != next_wd_state);

	// Effective state register.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wd_state <= WD_OFF;
		end else begin
			wd_state <= next_wd_state;
		end
	end

	// Millisecond counter; a trigger or new setting restarts it at once.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			count <= 13'h0000;
		end else if (restart) begin
			count <= 13'h0000;
		end else if (overflow) begin
			count <= 13'h0000;
		end else if (running && tick) begin
			count <= count_inc;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control register; reloaded with defaults while the chip sits in Reset.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			supervisor_mode_select <= RST_MODE;
			supervisor_period_select <= RST_PERIOD;
		end else if (chip_mode_i == CHIP_RESET) begin
			supervisor_mode_select <= software_dev_enable ? RST_MODE_SWDEV : RST_MODE;
			supervisor_period_select <= RST_PERIOD;
		end else if (accept) begin
			supervisor_mode_select <= wr_mode;
			supervisor_period_select <= wr_period;
		end
	end

	// Boot configuration; stands in for non-volatile storage with factory presets.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			{startup_undervoltage_level, forced_normal_enable, software_dev_enable} <= RST_BOOT_FIELDS;
		end else if (wr_boot) begin
			startup_undervoltage_level <= reg_req_i.wdata[BOOT_UV_LSB +: 2];
			forced_normal_enable <= reg_req_i.wdata[BOOT_FN_BIT];
			software_dev_enable <= reg_req_i.wdata[BOOT_SD_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Failure flag: a Timeout overflow sets it only while it is clear; once set, the clear wins over an overflow in the same cycle.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			failure_pending <= 1'b0;
		end else if (overflow && (wd_state == WD_TIMEOUT) && !failure_pending) begin
			failure_pending <= 1'b1;
		end else if (failure_clear_i) begin
			failure_pending <= 1'b0;
		end
	end

	// Wake-up signalling on the receive pin, set wins over clear.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wake_low <= 1'b0;
		end else if (wake_restart) begin
			wake_low <= 1'b1;
		end else if (wake_clear_i) begin
			wake_low <= 1'b0;
		end
	end

	// Normal-entry flag: set at power-up, cleared on the first Normal entry.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			normal_entry_pending <= RST_NORMAL_ENTRY_PENDING;
		end else if (off_exit_i) begin
			normal_entry_pending <= RST_NORMAL_ENTRY_PENDING;
		end else if (chip_mode_i == CHIP_NORMAL) begin
			normal_entry_pending <= 1'b0;
		end
	end

	// Reset origin; supply and temperature events outrank watchdog causes.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reset_origin <= ORG_OFF_EXIT;
		end else if (off_exit_i) begin
			reset_origin <= ORG_OFF_EXIT;
		end else if (overtemp_exit_i) begin
			reset_origin <= ORG_OVERTEMP;
		end else if (undervoltage_i) begin
			reset_origin <= ORG_UNDERVOLT;
		end else if (reset_pin_low_i) begin
			reset_origin <= ORG_EXT_PIN;
		end else if (illegal) begin
			reset_origin <= ORG_ILLEGAL;
		end else if (early) begin
			reset_origin <= ORG_EARLY;
		end else if (fail_reset) begin
			reset_origin <= ORG_OVERFLOW;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Event outputs, one-cycle pulses.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sys_reset_req_o <= 1'b0;
			serial_failure_event_o <= 1'b0;
		end else begin
			sys_reset_req_o <= illegal || early || fail_reset;
			serial_failure_event_o <= serial_failure_enable_i && (illegal || bad_code);
		end
	end

	// Level outputs mirrored in flops.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			supervisor_state_o <= WDS_OFF;
			supervisor_failure_event_o <= 1'b0;
			wake_signal_low_o <= 1'b0;
			forced_normal_enable_o <= 1'b0;
			software_dev_enable_o <= 1'b0;
			startup_undervoltage_level_o <= 2'h0;
			undervoltage_percent_o <= UV_PCT_00;
		end else begin
			if (wd_state == WD_OFF) begin
				supervisor_state_o <= WDS_OFF;
			end else begin
				supervisor_state_o <= (count < half_ms) ? WDS_FIRST : WDS_SECOND;
			end
			supervisor_failure_event_o <= failure_pending;
			wake_signal_low_o <= wake_low;
			forced_normal_enable_o <= forced_normal_enable;
			software_dev_enable_o <= software_dev_enable;
			startup_undervoltage_level_o <= startup_undervoltage_level;
			case (startup_undervoltage_level)
				2'h0: undervoltage_percent_o <= UV_PCT_00;
				2'h1: undervoltage_percent_o <= UV_PCT_01;
				2'h2: undervoltage_percent_o <= UV_PCT_10;
				default: undervoltage_percent_o <= UV_PCT_11;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read port; data appears the cycle after the read strobe, unmapped reads zero.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_req_i.rd) begin
			case (reg_req_i.addr)
				ADDR_WATCHDOG_CONTROL: reg_rdata_o <= {supervisor_mode_select, 1'b0, supervisor_period_select};
				ADDR_MAIN_STATUS: reg_rdata_o <= {2'h0, normal_entry_pending, reset_origin};
				ADDR_WATCHDOG_STATUS: reg_rdata_o <= {4'h0, (chip_mode_i == CHIP_FORCED_NORMAL),
					software_dev_enable, supervisor_state_o};
				ADDR_BOOT_CONFIGURATION: reg_rdata_o <= {2'h0, startup_undervoltage_level,
					forced_normal_enable, software_dev_enable, 2'h0};
				default: reg_rdata_o <= 8'h00;
			endcase
		end
	end

endmodule // sbcwd_watchdog

// ### hw/sbcwd_pkg.sv
// Behaviour
// - Normal-entry status reads 1 from power-up until Normal is first entered.
// - Reset origin: 01110 early trigger, 01111 overflow, 10000 illegal reconfiguration.
// - Reset origin: 00000 Off exit, 10001 external pin, 10010 Overtemp, 10011 undervoltage.
// - Window operation only in Normal; a trigger in the open half restarts the timer.
// - Timeout runs continuously; any trigger before expiry restarts the timer.
// - Timeout may serve as periodic wake-up source for the microcontroller.
// - Mode field bits 7:5 decode 001 Autonomous, 010 Timeout, 100 Window.
// - Window selected in Standby or Sleep runs as Timeout, switching to Window in Normal.
// - Changing mode or period in Normal forces reset, origin 10000, serial failure.
// - Period codes map to 8 to 4096 ms, shared by Window and Timeout.
// - Defaults: period 128 ms (0100), mode Timeout (010).
// - Every valid control write is a trigger restarting the timer.
// - New valid mode or period settings take effect immediately.
// - Undefined mode or period codes discard the write and raise serial failure.
// - Forced-normal enable keeps the watchdog off in every operating mode.
// - Autonomous: off with software-development, else Timeout in Normal, off elsewhere except Standby with receive pin low.
// - Standby Autonomous without software-development: Timeout when receive pin low.
// - Forced-normal from boot bit 3, software-development bit 2; presets 1 and 0.
// - Start-up undervoltage field: 00 90%, 01 80%, 10 70%, 11 60%; preset 00.
// - Watchdog state field: 00 off, 01 first half, 10 second half.
// - Read-only bits show forced-normal and software-development activity.
// - Window overflow or first-half trigger performs a system reset.
// - Timeout overflow captures a failure event; overflow with one pending resets.
// - Autonomous Standby wake-up drives receive pin low and restarts Timeout.
package sbcwd_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register offsets.
	localparam logic [6:0] ADDR_WATCHDOG_CONTROL = 7'h00;
	localparam logic [6:0] ADDR_MAIN_STATUS = 7'h03;
	localparam logic [6:0] ADDR_WATCHDOG_STATUS = 7'h05;
	localparam logic [6:0] ADDR_BOOT_CONFIGURATION = 7'h74;

	// Field positions.
	localparam int MODE_LSB = 5;
	localparam int PERIOD_LSB = 0;
	localparam int BOOT_FN_BIT = 3;
	localparam int BOOT_SD_BIT = 2;
	localparam int BOOT_UV_LSB = 4;

	////////////////////////////////////////////////////////////////////////////
	// Mode and period codes.
	localparam logic [2:0] MODE_AUTONOMOUS = 3'h1;
	localparam logic [2:0] MODE_TIMEOUT = 3'h2;
	localparam logic [2:0] MODE_WINDOW = 3'h4;
	localparam logic [3:0] PER_8 = 4'h8;
	localparam logic [3:0] PER_16 = 4'h1;
	localparam logic [3:0] PER_32 = 4'h2;
	localparam logic [3:0] PER_64 = 4'hB;
	localparam logic [3:0] PER_128 = 4'h4;
	localparam logic [3:0] PER_256 = 4'hD;
	localparam logic [3:0] PER_1024 = 4'hE;
	localparam logic [3:0] PER_4096 = 4'h7;

	// Values after reset.
	localparam logic [2:0] RST_MODE = MODE_TIMEOUT;
	localparam logic [2:0] RST_MODE_SWDEV = MODE_AUTONOMOUS;
	localparam logic [3:0] RST_PERIOD = PER_128;
	localparam logic [3:0] RST_BOOT_FIELDS = 4'h2;
	localparam logic RST_NORMAL_ENTRY_PENDING = 1'b1;

	// Reset origin codes.
	localparam logic [4:0] ORG_OFF_EXIT = 5'h00;
	localparam logic [4:0] ORG_EARLY = 5'h0E;
	localparam logic [4:0] ORG_OVERFLOW = 5'h0F;
	localparam logic [4:0] ORG_ILLEGAL = 5'h10;
	localparam logic [4:0] ORG_EXT_PIN = 5'h11;
	localparam logic [4:0] ORG_OVERTEMP = 5'h12;
	localparam logic [4:0] ORG_UNDERVOLT = 5'h13;

	// Watchdog state field and undervoltage percentages.
	localparam logic [1:0] WDS_OFF = 2'h0;
	localparam logic [1:0] WDS_FIRST = 2'h1;
	localparam logic [1:0] WDS_SECOND = 2'h2;
	localparam logic [6:0] UV_PCT_00 = 7'h5A;
	localparam logic [6:0] UV_PCT_01 = 7'h50;
	localparam logic [6:0] UV_PCT_10 = 7'h46;
	localparam logic [6:0] UV_PCT_11 = 7'h3C;

	////////////////////////////////////////////////////////////////////////////
	// Timebase: one millisecond tick derived from the core clock.
	localparam int CLK_PERIOD_NS = 50;
	localparam int TICK_TIME_US = 1000;
	localparam int TICK_CYCLES = TICK_TIME_US * 1000 / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////
	// Chip operating mode, one-hot, supplied by the mode controller.
	typedef enum logic [6:0] {
		CHIP_OFF = 7'h01,
		CHIP_FORCED_NORMAL = 7'h02,
		CHIP_STANDBY = 7'h04,
		CHIP_NORMAL = 7'h08,
		CHIP_RESET = 7'h10,
		CHIP_OVERTEMP = 7'h20,
		CHIP_SLEEP = 7'h40
	} sbcwd_chip_mode_t;

	// Effective watchdog operation.
	typedef enum logic [2:0] {
		WD_OFF = 3'h1,
		WD_TIMEOUT = 3'h2,
		WD_WINDOW = 3'h4
	} sbcwd_wd_state_t;

	// One register access as delivered by the serial frame decoder.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} sbcwd_reg_req_t;

endpackage

// ### hw/sbcwd_code_check.sv
`timescale 1ns/1ns
// Checks mode and period codes and gives the period in milliseconds.
module sbcwd_code_check import sbcwd_pkg::*; (
	input wire logic [2:0] mode_code_i,
	input wire logic [3:0] period_code_i,
	output logic mode_ok_o,
	output logic period_ok_o,
	output logic [12:0] period_ms_o
);

	// Only three mode codes are legal; redundancy rejects single-bit slips.
	always_comb begin
		mode_ok_o = (mode_code_i == MODE_AUTONOMOUS) || (mode_code_i == MODE_TIMEOUT) ||
			(mode_code_i == MODE_WINDOW);
	end

	// Period lookup; unknown codes report zero and are flagged.
	always_comb begin
		period_ok_o = 1'b1;
		case (period_code_i)
			PER_8: period_ms_o = 13'h0008;
			PER_16: period_ms_o = 13'h0010;
			PER_32: period_ms_o = 13'h0020;
			PER_64: period_ms_o = 13'h0040;
			PER_128: period_ms_o = 13'h0080;
			PER_256: period_ms_o = 13'h0100;
			PER_1024: period_ms_o = 13'h0400;
			PER_4096: period_ms_o = 13'h1000;
			default: begin
				period_ms_o = 13'h0000;
				period_ok_o = 1'b0;
			end
		endcase
	end

endmodule // sbcwd_code_check

// ### hw/sbcwd_tick_gen.sv
`timescale 1ns/1ns
// Free-running millisecond tick, independent of any register traffic.
module sbcwd_tick_gen #(
	parameter int unsigned CYCLES = 20000
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	output logic tick_o
);

	localparam int W = $clog2(CYCLES);
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);

	logic [W-1:0] count;

	// Divider; never reset by bus activity so timing continues when idle.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			count <= '0;
			tick_o <= 1'b0;
		end else begin
			tick_o <= (count == LAST);
			count <= (count == LAST) ? '0 : W'(count + 1'b1);
		end
	end

endmodule // sbcwd_tick_gen

// ### sim/sbcwd_watchdog_sva.sv
`timescale 1ns/1ns
// Port-level checker for the supervisor, all in the core clock domain.
module sbcwd_watchdog_sva import sbcwd_pkg::*; #(
	parameter int unsigned TICK_CYC = 4
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire sbcwd_reg_req_t reg_req_i,
	input wire sbcwd_chip_mode_t chip_mode_i,
	input wire logic failure_clear_i,
	input wire logic serial_failure_enable_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic sys_reset_req_o,
	input wire logic serial_failure_event_o,
	input wire logic supervisor_failure_event_o,
	input wire logic [1:0] supervisor_state_o,
	input wire logic software_dev_enable_o,
	input wire logic [1:0] startup_undervoltage_level_o,
	input wire logic [6:0] undervoltage_percent_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	localparam logic [6:0] PCT [4] = '{UV_PCT_00, UV_PCT_01, UV_PCT_10, UV_PCT_11};
	logic bad_mode;
	////////////////////////////////////////////////////////////////////////////
	// A mode code outside the three legal ones must be refused loudly.
	assign bad_mode = !(reg_req_i.wdata[7:5] inside {MODE_AUTONOMOUS, MODE_TIMEOUT, MODE_WINDOW});
	a_bad_code_flag: assert property (
		reg_req_i.wr && reg_req_i.addr == ADDR_WATCHDOG_CONTROL && bad_mode && serial_failure_enable_i
		|-> ##[1:3] serial_failure_event_o) else $error("bad control code without serial failure");
	a_reset_single: assert property (sys_reset_req_o |=> !sys_reset_req_o)
		else $error("system reset request longer than one cycle");
	a_sfail_single: assert property (serial_failure_event_o |=> !serial_failure_event_o)
		else $error("serial failure longer than one cycle");
	a_forced_stays_off: assert property (
		(chip_mode_i == CHIP_FORCED_NORMAL)[*3] |-> supervisor_state_o == WDS_OFF)
		else $error("watchdog running in forced normal");
	a_other_modes_off: assert property (
		(chip_mode_i inside {CHIP_OFF, CHIP_RESET, CHIP_OVERTEMP})[*3] |-> supervisor_state_o == WDS_OFF)
		else $error("watchdog running in a mode where it must be off");
	a_state_not_rsvd: assert property (supervisor_state_o != 2'h3) else $error("reserved watchdog state");
	a_uv_table: assert property (
		$stable(startup_undervoltage_level_o) |=> undervoltage_percent_o == PCT[startup_undervoltage_level_o])
		else $error("undervoltage percentage does not match level");
	a_failure_holds: assert property (
		supervisor_failure_event_o && !$past(failure_clear_i) |=> supervisor_failure_event_o)
		else $error("failure event dropped without clear");
	a_status_bits: assert property (
		reg_req_i.rd && reg_req_i.addr == ADDR_WATCHDOG_STATUS |-> ##2
		reg_rdata_o[3:2] == {$past(chip_mode_i == CHIP_FORCED_NORMAL, 2), software_dev_enable_o})
		else $error("status bits do not show forced normal or development mode");
	// The main scenarios that the bench is meant to reach.
	c_sys_reset: cover property (sys_reset_req_o);
	c_failure: cover property ($rose(supervisor_failure_event_o));
	c_second_half: cover property (supervisor_state_o == WDS_SECOND);
endmodule // sbcwd_watchdog_sva

bind sbcwd_watchdog sbcwd_watchdog_sva #(.TICK_CYC(TICK_CYC)) i_sbcwd_watchdog_sva (.core_clk_i(core_clk_i),
	.nrst_i(nrst_i), .reg_req_i(reg_req_i), .chip_mode_i(chip_mode_i), .failure_clear_i(failure_clear_i),
	.serial_failure_enable_i(serial_failure_enable_i), .reg_rdata_o(reg_rdata_o), .sys_reset_req_o(sys_reset_req_o),
	.serial_failure_event_o(serial_failure_event_o), .supervisor_failure_event_o(supervisor_failure_event_o),
	.supervisor_state_o(supervisor_state_o), .software_dev_enable_o(software_dev_enable_o),
	.startup_undervoltage_level_o(startup_undervoltage_level_o), .undervoltage_percent_o(undervoltage_percent_o));

// ### sim/sbcwd_mcu_model.sv
`timescale 1ns/1ns
// Register-side partner: one single-byte access at a time.
module sbcwd_mcu_model import sbcwd_pkg::*; (
	input wire logic core_clk_i,
	input wire logic [7:0] reg_rdata_i,
	output sbcwd_reg_req_t reg_req_o
);
	// Released address and data are inverted so stale values never look live.
	initial reg_req_o = '0;
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		#5 reg_req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge core_clk_i);
		#5 reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	// Read data is registered, so it is taken two edges after the request.
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge core_clk_i);
		#5 reg_req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'hA5};
		@(posedge core_clk_i);
		#5 reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'h5A};
		@(posedge core_clk_i);
		#5 d = reg_rdata_i;
	endtask
endmodule // sbcwd_mcu_model

// ### sim/sbcwd_watchdog_tb_top.sv
`timescale 1ns/1ns
// Bench: one millisecond is shortened to four core cycles.
module sbcwd_watchdog_tb_top import sbcwd_pkg::*;;
	localparam int unsigned TICK = 4;
	localparam logic [6:0] PCT [4] = '{UV_PCT_00, UV_PCT_01, UV_PCT_10, UV_PCT_11};
	localparam logic [2:0] MODES [3] = '{MODE_AUTONOMOUS, MODE_TIMEOUT, MODE_WINDOW};
	localparam logic [3:0] PERS [8] = '{PER_8, PER_16, PER_32, PER_64, PER_128, PER_256, PER_1024, PER_4096};
	localparam logic [7:0] ORGS [4] = '{8'h20, 8'h32, 8'h33, 8'h31};
	logic core_clk, nrst_n, rxd_low, wake_cap, wake_clr, fail_clr, sf_en, sys_rst, sf_ev, wd_fail, wake_low;
	logic fn_en, sd_en;
	logic [3:0] cause;
	logic [7:0] rdata;
	logic [1:0] st, uv_lvl;
	logic [6:0] uv_pct;
	sbcwd_reg_req_t req;
	sbcwd_chip_mode_t chip;
	int mismatches, checks_done, rst_seen, sf_seen, cyc_cnt;
	sbcwd_watchdog #(.TICK_CYC(TICK)) i_sbcwd_watchdog (.core_clk_i(core_clk), .nrst_i(nrst_n), .reg_req_i(req),
		.chip_mode_i(chip), .rxd_low_i(rxd_low), .wake_up_captured_i(wake_cap), .wake_clear_i(wake_clr),
		.failure_clear_i(fail_clr), .serial_failure_enable_i(sf_en), .off_exit_i(cause[0]),
		.overtemp_exit_i(cause[1]), .undervoltage_i(cause[2]), .reset_pin_low_i(cause[3]), .reg_rdata_o(rdata),
		.sys_reset_req_o(sys_rst), .serial_failure_event_o(sf_ev), .supervisor_failure_event_o(wd_fail),
		.wake_signal_low_o(wake_low), .supervisor_state_o(st), .forced_normal_enable_o(fn_en),
		.software_dev_enable_o(sd_en), .startup_undervoltage_level_o(uv_lvl), .undervoltage_percent_o(uv_pct));
	sbcwd_mcu_model i_sbcwd_mcu_model (.core_clk_i(core_clk), .reg_rdata_i(rdata), .reg_req_o(req));
	////////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// Pulses are counted as they happen; a one-cycle event is easy to miss.
	always @(posedge core_clk) begin
		if (sys_rst === 1'b1) rst_seen++;
		if (sf_ev === 1'b1) sf_seen++;
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rdc(input logic [6:0] a, input logic [7:0] e, input string nm);
		logic [7:0] d;
		i_sbcwd_mcu_model.rd(a, d);
		chk(nm, e, d);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		i_sbcwd_mcu_model.wr(a, d);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#5;
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Main sequence; the chip sits in standby whenever it is reconfigured.
	initial begin
		{rxd_low, wake_cap, wake_clr, fail_clr, sf_en, cause, nrst_n} = '0;
		chip = CHIP_STANDBY;
		cyc(3);
		nrst_n = 1'b1;
		cyc(2);
		rdc(ADDR_WATCHDOG_CONTROL, 8'h44, "control");
		rdc(ADDR_BOOT_CONFIGURATION, 8'h08, "boot");
		wr(ADDR_MAIN_STATUS, 8'hFF);
		rdc(ADDR_MAIN_STATUS, 8'h20, "main");
		rdc(ADDR_WATCHDOG_STATUS, 8'h00, "wd_status");
		rdc(7'h10, 8'h00, "unmapped");
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_BOOT_CONFIGURATION, 8'(i << 4));
			cyc(3);
			chk("uv_pct", {1'b0, PCT[i]}, {1'b0, uv_pct});
			chk("boot_out", 8'(i << 2), {4'h0, uv_lvl, fn_en, sd_en});
		end
		wr(ADDR_BOOT_CONFIGURATION, 8'h00);
		sf_en = 1'b1;
		wr(ADDR_WATCHDOG_CONTROL, 8'h64);
		wr(ADDR_WATCHDOG_CONTROL, 8'h49);
		cyc(3);
		chk("sf_count", 8'h02, sf_seen[7:0]);
		rdc(ADDR_WATCHDOG_CONTROL, 8'h44, "control");
		for (int m = 0; m < 3; m++)
			for (int p = 0; p < 8; p++) begin
				wr(ADDR_WATCHDOG_CONTROL, {MODES[m], 1'b0, PERS[p]});
				rdc(ADDR_WATCHDOG_CONTROL, {MODES[m], 1'b0, PERS[p]}, "mode_period");
			end
		// Timeout at 8 ms: steady triggering keeps it quiet, then two overflows end in a reset.
		repeat (5) begin
			wr(ADDR_WATCHDOG_CONTROL, 8'h48);
			cyc(20);
		end
		chk("wd_fail", 8'h00, {7'h00, wd_fail});
		cyc(20);
		chk("wd_fail", 8'h01, {7'h00, wd_fail});
		cyc(36);
		chk("resets", 8'h01, rst_seen[7:0]);
		rdc(ADDR_MAIN_STATUS, 8'h2F, "main");
		fail_clr = 1'b1;
		cyc(1);
		fail_clr = 1'b0;
		wr(ADDR_WATCHDOG_CONTROL, 8'h88);
		chip = CHIP_SLEEP;
		cyc(3);
		chk("state", 8'h01, {6'h00, st});
		chip = CHIP_NORMAL;
		cyc(3);
		rdc(ADDR_MAIN_STATUS, 8'h0F, "main");
		wr(ADDR_WATCHDOG_CONTROL, 8'h88);
		cyc(3);
		chk("resets", 8'h02, rst_seen[7:0]);
		rdc(ADDR_MAIN_STATUS, 8'h0E, "main");
		cyc(18);
		wr(ADDR_WATCHDOG_CONTROL, 8'h88);
		rdc(ADDR_WATCHDOG_STATUS, 8'h01, "wd_status");
		chk("resets", 8'h02, rst_seen[7:0]);
		wr(ADDR_WATCHDOG_CONTROL, 8'h48);
		cyc(3);
		chk("resets", 8'h03, rst_seen[7:0]);
		chk("sf_count", 8'h03, sf_seen[7:0]);
		rdc(ADDR_WATCHDOG_CONTROL, 8'h88, "control");
		rdc(ADDR_MAIN_STATUS, 8'h10, "main");
		cyc(40);
		chk("resets", 8'h04, rst_seen[7:0]);
		rdc(ADDR_MAIN_STATUS, 8'h0F, "main");
		// Reset mode reloads the control defaults and holds the watchdog off.
		chip = CHIP_RESET;
		cyc(2);
		rdc(ADDR_WATCHDOG_CONTROL, 8'h44, "control");
		rdc(ADDR_WATCHDOG_STATUS, 8'h00, "wd_status");
		for (int i = 0; i < 4; i++) begin
			cause = 4'(1 << i);
			cyc(1);
			cause = 4'h0;
			cyc(2);
			rdc(ADDR_MAIN_STATUS, ORGS[i], "origin");
		end
		chip = CHIP_FORCED_NORMAL;
		cyc(4);
		rdc(ADDR_WATCHDOG_STATUS, 8'h08, "wd_status");
		chip = CHIP_STANDBY;
		wr(ADDR_WATCHDOG_CONTROL, 8'h28);
		cyc(3);
		rdc(ADDR_WATCHDOG_STATUS, 8'h00, "wd_status");
		rxd_low = 1'b1;
		cyc(3);
		rdc(ADDR_WATCHDOG_STATUS, 8'h01, "wd_status");
		rxd_low = 1'b0;
		cyc(3);
		rdc(ADDR_WATCHDOG_STATUS, 8'h00, "wd_status");
		wake_cap = 1'b1;
		cyc(1);
		wake_cap = 1'b0;
		cyc(3);
		chk("wake_low", 8'h01, {7'h00, wake_low});
		rdc(ADDR_WATCHDOG_STATUS, 8'h01, "wd_status");
		wake_clr = 1'b1;
		cyc(1);
		wake_clr = 1'b0;
		wr(ADDR_BOOT_CONFIGURATION, 8'h04);
		cyc(3);
		rdc(ADDR_WATCHDOG_STATUS, 8'h04, "wd_status");
		tally_and_finish();
	end
endmodule // sbcwd_watchdog_tb_top
